// ===== tb_vgc_video_gen.sv
`timescale 1ns/1ns
// Self-checking bench: registers, frame buffer, pin routing, chroma gating and pacing
module tb_vgc_video_gen;
   logic clk, sys_rst, config_wr, scale_wr, wait_valid, wait_ready, core_pll_clock, aural_out;
   logic [31:0] reg_wdata, config_rdata, scale_rdata, pin_out, pin_oe, seed, v, col;
   logic [7:0] core_pll_all, mask, eb;
   logic [11:0] ticks_last;
   logic [2:0] g;
   logic [1:0] mode, k;
   vgc_pkg::vgc_frame_type wait_frame;
   int n_errors, compares;

   vgc_video_gen i_dut (.clk(clk), .sys_rst(sys_rst), .config_wr(config_wr), .scale_wr(scale_wr),
      .reg_wdata(reg_wdata), .config_rdata(config_rdata), .scale_rdata(scale_rdata),
      .wait_valid(wait_valid), .wait_ready(wait_ready), .wait_frame(wait_frame),
      .core_pll_clock(core_pll_clock), .core_pll_all(core_pll_all), .pin_out(pin_out),
      .pin_oe(pin_oe), .aural_out(aural_out));
   vgc_display_model i_display (.clk(clk), .core_pll_clock(core_pll_clock), .pin_out(pin_out),
      .pin_oe(pin_oe), .ticks_last(ticks_last));

   // System clock, 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Xorshift source with a fixed start, so every run repeats
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Configuration word from its fields
   function automatic logic [31:0] cfg(input logic [1:0] md, input logic fm, input logic bc, input logic bb,
      input logic [2:0] au, input logic [2:0] gr, input logic [7:0] mk);
      return {1'h0, md, fm, bc, bb, au, 11'h000, gr, 1'h0, mk};
   endfunction : cfg

   // Colour byte with its chroma bits gated as the composite layout puts them
   function automatic logic [7:0] pin_byte(input logic [1:0] md, input logic bc, input logic bb, input logic [7:0] c);
      pin_byte = c;
      if (md == 2'h2) begin
         pin_byte[7] = c[7] & bc;
         pin_byte[3] = c[3] & bb;
      end else if (md == 2'h3) begin
         pin_byte[7] = c[7] & bb;
         pin_byte[3] = c[3] & bc;
      end
   endfunction : pin_byte

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic stop_test();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   // One-cycle write strobe; sel 0 is the configuration, 1 the scale
   task automatic wr_reg(input logic sel, input logic [31:0] d);
      @(posedge clk);
      config_wr <= ~sel;
      scale_wr <= sel;
      reg_wdata <= d;
      @(posedge clk);
      config_wr <= 1'b0;
      scale_wr <= 1'b0;
   endtask : wr_reg

   // Offer a frame and hold it until the edge where ready is seen high
   task automatic put_frame(input logic [31:0] c, input logic [31:0] p);
      int n;
      logic r;
      @(posedge clk);
      wait_valid <= 1'b1;
      wait_frame <= {c, p};
      n = 0;
      r = 1'b0;
      while (r !== 1'b1 && n < 5000) begin
         @(negedge clk);
         r = wait_ready;
         @(posedge clk);
         n++;
      end
      wait_valid <= 1'b0;
      check({31'h0, r}, 32'h1, "frame not taken");
   endtask : put_frame

   // One frame of constant pixels under a table-driven configuration
   task automatic show(input int i);
      logic [31:0] eo;
      mode = (i < 8) ? vgc_pkg::MODE_VGA : {1'b1, i[2]};
      g = (i < 8) ? i[2:0] : 3'h0;
      k = i[1:0];
      v = rnd();
      mask = (k == 2'h0) ? 8'h0F : (k == 2'h1) ? 8'hF0 : (k == 2'h2) ? 8'hFF : v[7:0];
      col = rnd() | 32'h8888_8888;
      wr_reg(1'b0, cfg(mode, i[2], i[0], i[1], i[2:0], g, mask));
      v = rnd();
      core_pll_all <= v[7:0];
      put_frame(col, i[2] ? {16{k}} : {32{k[0]}});
      repeat (40) @(posedge clk);
      #1;
      eb = pin_byte(mode, i[0], i[1], col[8 * (i[2] ? k : {1'b0, k[0]}) +: 8]);
      eo = (g < 4) ? ({24'h0, mask} << (8 * g)) : 32'h0;
      check(pin_oe, eo, "pin enables");
      check(pin_out & eo, ({24'h0, eb} << (8 * g)) & eo, "pin levels");
      check({31'h0, aural_out}, {31'h0, core_pll_all[i[2:0]]}, "audio source");
      repeat (120) @(posedge clk);
   endtask : show

   // Main sequence
   initial begin
      seed = 32'h0000_A4FD;
      n_errors = 0;
      compares = 0;
      sys_rst = 1'b1;
      config_wr = 1'b0;
      scale_wr = 1'b0;
      reg_wdata = 32'h0;
      wait_valid = 1'b0;
      wait_frame = '0;
      core_pll_all = 8'h00;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(config_rdata, vgc_pkg::CONFIG_RESET, "config reset");
      check(scale_rdata, vgc_pkg::SCALE_RESET, "scale reset");
      check(pin_oe, 32'h0, "pins idle");
      check({31'h0, wait_ready}, 32'h1, "ready after reset");
      // Random writes to both registers, one idle cycle apart, then read back
      for (int i = 0; i < 6; i++) begin
         v = rnd();
         col = rnd();
         wr_reg(1'b0, v);
         wr_reg(1'b1, col);
         repeat (2) @(posedge clk);
         #1;
         check(config_rdata, v, "config read");
         check(scale_rdata, col & 32'h000F_FFFF, "scale read");
      end
      // Generator off: two frames fill the buffer and nothing more is taken
      wr_reg(1'b0, 32'h0);
      wr_reg(1'b1, {12'h000, 8'h01, 12'h010});
      put_frame(32'h0000_2211, 32'h0);
      put_frame(32'h0000_2211, 32'hFFFF_FFFF);
      repeat (3) @(posedge clk);
      #1;
      check({31'h0, wait_ready}, 32'h0, "buffer full");
      check(pin_oe, 32'h0, "mode off");
      // Enabling drains the buffer; colours change only at frame ends, then underrun stops the pins
      wr_reg(1'b0, cfg(vgc_pkg::MODE_VGA, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0, 8'hFF));
      put_frame(32'h0000_2211, 32'h0);
      put_frame(32'h0000_2211, 32'hFFFF_FFFF);
      for (int n = 0; n < 3000 && pin_oe !== 32'h0; n++) begin
         @(posedge clk);
         #1;
      end
      check(pin_oe, 32'h0, "underrun");
      // The display sees the pins go dark one edge later; let it log that change first
      repeat (2) @(posedge clk);
      #1;
      check({20'h0, ticks_last}, 32'h10, "frame period");
      // Alternating one-bit pixels, 3 ticks each, 32 pixels per frame
      wr_reg(1'b1, {12'h000, 8'h03, 12'h060});
      put_frame(32'h0000_2211, 32'hAAAA_AAAA);
      repeat (150) @(posedge clk);
      #1;
      check({20'h0, ticks_last}, 32'h3, "pixel period");
      repeat (900) @(posedge clk);
      wr_reg(1'b1, {12'h000, 8'h01, 12'h010});
      for (int i = 0; i < 16; i++) show(i);
      stop_test();
   end

   // The run takes about 4200 cycles; cut a hang well beyond that
   initial begin
      #400000;
      n_errors++;
      stop_test();
   end
endmodule : tb_vgc_video_gen

// ===== vgc_display_model.sv
`timescale 1ns/1ns
// Display side: free-running core PLL clock and a timer for changes on the driven pins
module vgc_display_model (
   input wire logic clk,
   output logic core_pll_clock,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   output logic [11:0] ticks_last
);
   logic [11:0] tick_r;
   logic [11:0] stamp_r;
   logic [63:0] seen_r;

   // 70 ns PLL, offset so that its edges never meet a system clock edge
   initial begin
      core_pll_clock = 1'b0;
      #3;
      forever #35 core_pll_clock = ~core_pll_clock;
   end

   // Free tick count in the PLL domain
   initial tick_r = 12'h000;
   always @(posedge core_pll_clock) tick_r <= tick_r + 12'h001;

   // A screen sees only driven pins, so undriven levels are masked before comparing
   initial begin
      stamp_r = 12'h000;
      seen_r = 64'h0;
      ticks_last = 12'h000;
   end
   always @(posedge clk) begin
      if ({pin_oe, pin_out & pin_oe} != seen_r) begin
         ticks_last <= tick_r - stamp_r;
         stamp_r <= tick_r;
         seen_r <= {pin_oe, pin_out & pin_oe};
      end
   end
endmodule : vgc_display_model

// ===== vgc_frame_buf.sv
`timescale 1ns/1ns
// Two-entry buffer between the wait handshake and the generator
module vgc_frame_buf (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire vgc_pkg::vgc_frame_type in_data,
   output logic out_valid,
   input wire logic out_ready,
   output vgc_pkg::vgc_frame_type out_data
);
   vgc_pkg::vgc_frame_type mem_r [vgc_pkg::BUF_DEPTH];
   logic wr_ptr_r;
   logic rd_ptr_r;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_r[rd_ptr_r];
   assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};

   // Storage writes
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // Pointers and fill level; ready is registered so it never ripples back
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         cnt_r <= 2'h0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         cnt_r <= cnt_nxt;
         in_ready <= (cnt_nxt != 2'h2);
         out_valid <= (cnt_nxt != 2'h0);
      end
   end
endmodule : vgc_frame_buf

// ===== vgc_pkg.sv
package vgc_pkg;
   // Configuration register field positions
   localparam int MODE_HI = 30;
   localparam int MODE_LO = 29;
   localparam int CFMT_BIT = 28;
   localparam int BCAST_CHR_BIT = 27;
   localparam int BBAND_CHR_BIT = 26;
   localparam int AURAL_HI = 25;
   localparam int AURAL_LO = 23;
   localparam int GROUP_HI = 11;
   localparam int GROUP_LO = 9;
   localparam int MASK_HI = 7;
   localparam int MASK_LO = 0;
   // Scale register field positions
   localparam int PIXP_HI = 19;
   localparam int PIXP_LO = 12;
   localparam int FRMP_HI = 11;
   localparam int FRMP_LO = 0;
   // Values after reset
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   localparam logic [31:0] SCALE_RESET = 32'h0000_0000;
   // Output modes
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_VGA = 2'h1;
   localparam logic [1:0] MODE_COMP_BCAST_HI = 2'h2;
   localparam logic [1:0] MODE_COMP_BBAND_HI = 2'h3;
   // Pin groups beyond this code are reserved
   localparam logic [2:0] GROUP_LAST = 3'h3;
   // Pixels per frame word
   localparam logic [5:0] PIX_PER_WORD_2C = 6'h20;
   localparam logic [5:0] PIX_PER_WORD_4C = 6'h10;
   // Buffer depth and synchroniser length
   localparam int BUF_DEPTH = 2;
   localparam int SYNC_STAGES = 2;

   // One frame: 32-bit pixel word and four 8-bit colours
   typedef struct packed {
      logic [31:0] colours;
      logic [31:0] pixels;
   } vgc_frame_type;

   // Generator states, one-hot
   typedef enum logic [1:0] {
      VGC_IDLE = 2'h1,
      VGC_RUN = 2'h2
   } vgc_state_type;
endpackage : vgc_pkg

// ===== vgc_video_gen.sv
`timescale 1ns/1ns
module vgc_video_gen (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic config_wr,
   input wire logic scale_wr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] config_rdata,
   output logic [31:0] scale_rdata,
   input wire logic wait_valid,
   output logic wait_ready,
   input wire vgc_pkg::vgc_frame_type wait_frame,
   input wire logic core_pll_clock,
   input wire logic [7:0] core_pll_all,
   output logic [31:0] pin_out,
   output logic [31:0] pin_oe,
   output logic aural_out
);
   logic [31:0] video_config_r;
   logic [31:0] video_scale_r;
   logic [vgc_pkg::SYNC_STAGES-1:0] pll_sync_r;
   logic pll_prev_r;
   logic pll_tick;
   logic [7:0] aural_sync1_r;
   logic [7:0] aural_sync2_r;
   vgc_pkg::vgc_state_type state_r;
   logic [7:0] pix_cnt_r;
   logic [11:0] frm_cnt_r;
   logic [31:0] shift_r;
   logic [31:0] colours_r;
   logic buf_valid;
   logic buf_ready;
   vgc_pkg::vgc_frame_type buf_frame;
   logic pix_end;
   logic frm_end;
   logic [1:0] mode;
   logic [7:0] colour_byte;
   logic [7:0] video_byte;

   // Colour index from the bottom of the shift word
   function automatic logic [7:0] colour_pick(input logic [31:0] colours, input logic [31:0] pix, input logic cfmt);
      logic [1:0] idx;
      idx = cfmt ? pix[1:0] : {1'b0, pix[0]};
      return colours[{idx, 3'h0} +: 8];
   endfunction : colour_pick

   // Nibble with its chroma bit suppressed when colour is off
   function automatic logic [3:0] chroma_gate(input logic [3:0] nib, input logic en);
      return {nib[3] & en, nib[2:0]};
   endfunction : chroma_gate

   assign mode = video_config_r[vgc_pkg::MODE_HI:vgc_pkg::MODE_LO];

   vgc_frame_buf u_buf (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(wait_valid),
      .in_ready(wait_ready),
      .in_data(wait_frame),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_frame)
   );

   // Software register writes; configuration reads return the stored value, scale reads its bits 19:0
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         video_config_r <= vgc_pkg::CONFIG_RESET;
         video_scale_r <= vgc_pkg::SCALE_RESET;
      end else begin
         if (config_wr) begin
            video_config_r <= reg_wdata;
         end
         if (scale_wr) begin
            video_scale_r <= reg_wdata;
         end
      end
   end

   // Read ports are flops; unused bits of the scale register read as zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         config_rdata <= vgc_pkg::CONFIG_RESET;
         scale_rdata <= vgc_pkg::SCALE_RESET;
      end else begin
         config_rdata <= video_config_r;
         scale_rdata <= {12'h000, video_scale_r[vgc_pkg::PIXP_HI:0]};
      end
   end

   // PLL clock is foreign to clk: two flops, then an edge detect on the second
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pll_sync_r <= '0;
         pll_prev_r <= 1'b0;
      end else begin
         pll_sync_r <= {pll_sync_r[0], core_pll_clock};
         pll_prev_r <= pll_sync_r[1];
      end
   end

   assign pll_tick = pll_sync_r[1] && !pll_prev_r;
   // A period of zero or one both mean one PLL clock; zero cannot stall the shifter
   assign pix_end = pll_tick && (pix_cnt_r <= 8'h01);
   assign frm_end = pll_tick && (frm_cnt_r <= 12'h001);
   // While running, the next word is taken only at frame end; idle takes one as soon as video is on
   assign buf_ready = (state_r == vgc_pkg::VGC_IDLE) ? (mode != vgc_pkg::MODE_OFF) : frm_end;

   // Generator sequencing
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= vgc_pkg::VGC_IDLE;
      end else begin
         case (state_r)
            vgc_pkg::VGC_IDLE: begin
               if (mode != vgc_pkg::MODE_OFF && buf_valid) begin
                  state_r <= vgc_pkg::VGC_RUN;
               end
            end
            vgc_pkg::VGC_RUN: begin
               if (mode == vgc_pkg::MODE_OFF) begin
                  state_r <= vgc_pkg::VGC_IDLE;
               end else if (frm_end && !buf_valid) begin
                  state_r <= vgc_pkg::VGC_IDLE; // Underrun: wait for software
               end
            end
            default: begin
               state_r <= vgc_pkg::VGC_IDLE;
            end
         endcase
      end
   end

   // Pixel and frame counters run on PLL ticks only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pix_cnt_r <= 8'h00;
         frm_cnt_r <= 12'h000;
      end else if (state_r != vgc_pkg::VGC_RUN || frm_end) begin
         pix_cnt_r <= video_scale_r[vgc_pkg::PIXP_HI:vgc_pkg::PIXP_LO];
         frm_cnt_r <= video_scale_r[vgc_pkg::FRMP_HI:vgc_pkg::FRMP_LO];
      end else if (pll_tick) begin
         frm_cnt_r <= frm_cnt_r - 12'h001;
         if (pix_end) begin
            pix_cnt_r <= video_scale_r[vgc_pkg::PIXP_HI:vgc_pkg::PIXP_LO];
         end else begin
            pix_cnt_r <= pix_cnt_r - 8'h01;
         end
      end
   end

   // Word load and pixel shifting
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shift_r <= 32'h0000_0000;
         colours_r <= 32'h0000_0000;
      end else if (buf_valid && buf_ready) begin
         shift_r <= buf_frame.pixels;
         colours_r <= buf_frame.colours;
      end else if (state_r == vgc_pkg::VGC_RUN && pix_end) begin
         if (video_config_r[vgc_pkg::CFMT_BIT]) begin
            shift_r <= {2'h0, shift_r[31:2]};
         end else begin
            shift_r <= {1'h0, shift_r[31:1]};
         end
      end
   end

   assign colour_byte = colour_pick(colours_r, shift_r, video_config_r[vgc_pkg::CFMT_BIT]);

   // Lay the colour byte out for the selected mode
   always_comb begin
      video_byte = 8'h00;
      case (mode)
         vgc_pkg::MODE_VGA: begin
            video_byte = colour_byte;
         end
         vgc_pkg::MODE_COMP_BCAST_HI: begin
            video_byte = {chroma_gate(colour_byte[7:4], video_config_r[vgc_pkg::BCAST_CHR_BIT]),
                          chroma_gate(colour_byte[3:0], video_config_r[vgc_pkg::BBAND_CHR_BIT])};
         end
         vgc_pkg::MODE_COMP_BBAND_HI: begin
            video_byte = {chroma_gate(colour_byte[7:4], video_config_r[vgc_pkg::BBAND_CHR_BIT]),
                          chroma_gate(colour_byte[3:0], video_config_r[vgc_pkg::BCAST_CHR_BIT])};
         end
         default: begin
            video_byte = 8'h00;
         end
      endcase
   end

   // Pin routing; reserved groups and an idle generator drive nothing
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_out <= 32'h0000_0000;
         pin_oe <= 32'h0000_0000;
      end else begin
         pin_out <= 32'h0000_0000;
         pin_oe <= 32'h0000_0000;
         if (state_r == vgc_pkg::VGC_RUN && video_config_r[vgc_pkg::GROUP_HI:vgc_pkg::GROUP_LO] <= vgc_pkg::GROUP_LAST) begin
            pin_out[{video_config_r[vgc_pkg::GROUP_LO +: 2], 3'h0} +: 8] <=
               video_byte & video_config_r[vgc_pkg::MASK_HI:vgc_pkg::MASK_LO];
            pin_oe[{video_config_r[vgc_pkg::GROUP_LO +: 2], 3'h0} +: 8] <=
               video_config_r[vgc_pkg::MASK_HI:vgc_pkg::MASK_LO];
         end
      end
   end

   // Audio sub-carrier: every core PLL is synchronised, then one is picked
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aural_sync1_r <= 8'h00;
         aural_sync2_r <= 8'h00;
         aural_out <= 1'b0;
      end else begin
         aural_sync1_r <= core_pll_all;
         aural_sync2_r <= aural_sync1_r;
         aural_out <= aural_sync2_r[video_config_r[vgc_pkg::AURAL_HI:vgc_pkg::AURAL_LO]];
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_mode_off_dark: assert property ((mode == vgc_pkg::MODE_OFF) |-> ##2 (pin_oe == 32'h0000_0000))
      else $error("Pins driven with video off");
   a_cfg_readback: assert property (config_wr |-> ##2 (config_rdata == $past(reg_wdata, 2)))
      else $error("Configuration readback wrong");
   a_scl_readback: assert property (scale_wr |-> ##2 (scale_rdata[19:0] == $past(reg_wdata[19:0], 2)))
      else $error("Scale readback wrong");
   a_shift_two: assert property ((state_r == vgc_pkg::VGC_RUN && pix_end && !buf_ready
      && video_config_r[vgc_pkg::CFMT_BIT]) |=> (shift_r == {2'h0, $past(shift_r[31:2])}))
      else $error("Four-colour shift wrong");
   a_shift_one: assert property ((state_r == vgc_pkg::VGC_RUN && pix_end && !buf_ready
      && !video_config_r[vgc_pkg::CFMT_BIT]) |=> (shift_r == {1'h0, $past(shift_r[31:1])}))
      else $error("Two-colour shift wrong");
   a_pix_reload: assert property ((state_r == vgc_pkg::VGC_RUN && pix_end && !frm_end && !scale_wr)
      |=> (pix_cnt_r == video_scale_r[vgc_pkg::PIXP_HI:vgc_pkg::PIXP_LO]))
      else $error("Pixel counter not reloaded");
   a_frm_count: assert property ((state_r == vgc_pkg::VGC_RUN && pll_tick && !frm_end)
      |=> (frm_cnt_r == $past(frm_cnt_r) - 12'h001))
      else $error("Frame counter not counting");
   a_word_at_end: assert property ((state_r == vgc_pkg::VGC_RUN && buf_valid && buf_ready)
      |-> frm_end ##1 (shift_r == $past(buf_frame.pixels)))
      else $error("Word taken outside frame end");
   a_mask_gate: assert property ((pin_oe & ~{4{config_rdata[vgc_pkg::MASK_HI:vgc_pkg::MASK_LO]}}) == 32'h0000_0000
      || $past(config_wr) || $past(config_wr, 2))
      else $error("Unmasked pin driven");
   a_reserved_group: assert property ((video_config_r[vgc_pkg::GROUP_HI] && !config_wr) |=> (pin_oe == 32'h0000_0000))
      else $error("Reserved group drives pins");
   a_aural_pick: assert property (!config_wr |-> ##1 (aural_out
      == $past(aural_sync2_r[video_config_r[vgc_pkg::AURAL_HI:vgc_pkg::AURAL_LO]])))
      else $error("Audio source wrong");

   // Enables land on the chosen group only, one cycle after the routing decision
   a_oe_mask: assert property ((state_r == vgc_pkg::VGC_RUN && !video_config_r[vgc_pkg::GROUP_HI])
      |=> (pin_oe == ({24'h00_0000, $past(video_config_r[vgc_pkg::MASK_HI:vgc_pkg::MASK_LO])}
      << {$past(video_config_r[vgc_pkg::GROUP_LO +: 2]), 3'h0})))
      else $error("Pin enables off the mask");
   // Two-colour VGA on group 0: the pixel bit picks colour 0 or colour 1
   a_vga_byte: assert property ((state_r == vgc_pkg::VGC_RUN && mode == vgc_pkg::MODE_VGA
      && !video_config_r[vgc_pkg::CFMT_BIT] && video_config_r[vgc_pkg::GROUP_HI:vgc_pkg::GROUP_LO] == 3'h0)
      |=> (pin_out[7:0] == ($past(shift_r[0] ? colours_r[15:8] : colours_r[7:0])
      & $past(video_config_r[vgc_pkg::MASK_HI:vgc_pkg::MASK_LO]))))
      else $error("VGA pin byte wrong");
   // A cleared chroma enable keeps the chroma bit of the upper nibble low
   a_bcast_chroma: assert property ((state_r == vgc_pkg::VGC_RUN && mode == vgc_pkg::MODE_COMP_BCAST_HI
      && !video_config_r[vgc_pkg::BCAST_CHR_BIT] && video_config_r[vgc_pkg::GROUP_HI:vgc_pkg::GROUP_LO] == 3'h0)
      |=> !pin_out[7])
      else $error("Broadcast chroma not suppressed");
   a_bband_chroma: assert property ((state_r == vgc_pkg::VGC_RUN && mode == vgc_pkg::MODE_COMP_BBAND_HI
      && !video_config_r[vgc_pkg::BBAND_CHR_BIT] && video_config_r[vgc_pkg::GROUP_HI:vgc_pkg::GROUP_LO] == 3'h0)
      |=> !pin_out[7])
      else $error("Baseband chroma not suppressed");
   a_frm_reload: assert property ((state_r == vgc_pkg::VGC_RUN && frm_end && !scale_wr)
      |=> (frm_cnt_r == video_scale_r[vgc_pkg::FRMP_HI:vgc_pkg::FRMP_LO]))
      else $error("Frame counter not reloaded");
   a_idle_dark: assert property ((state_r == vgc_pkg::VGC_IDLE) |=> (pin_oe == 32'h0000_0000))
      else $error("Pins driven while idle");
   // With video off the shifter must not move, so a later enable starts on a whole word
   a_off_holds: assert property ((state_r == vgc_pkg::VGC_IDLE && mode == vgc_pkg::MODE_OFF)
      |=> $stable(shift_r))
      else $error("Shifter moved with video off");

   c_vga_run: cover property (state_r == vgc_pkg::VGC_RUN && mode == vgc_pkg::MODE_VGA ##1 pix_end);
   c_frame_chain: cover property (frm_end && buf_valid ##1 (state_r == vgc_pkg::VGC_RUN));
   c_underrun: cover property (state_r == vgc_pkg::VGC_RUN && frm_end && !buf_valid);
   c_buf_full: cover property (!wait_ready && wait_valid);
endmodule : vgc_video_gen
